/* File: design/espc_pkg.sv */
package espc_pkg;
	localparam int unsigned BYTE_W   = 8;
	localparam int unsigned CNT_W    = 3;
	localparam int unsigned PIN_N    = 5;
	// positions of the pins inside the synchroniser vector
	localparam int unsigned PIN_CS   = 0;
	localparam int unsigned PIN_SCK  = 1;
	localparam int unsigned PIN_MOSI = 2;
	localparam int unsigned PIN_WP   = 3;
	localparam int unsigned PIN_HOLD = 4;
	// synchroniser reset value: select, protect and pause pins idle high
	localparam logic [PIN_N-1:0] PIN_RST  = 5'h19;
	localparam logic [BYTE_W-1:0] SHIFT_RST = 8'h00;
	localparam logic [CNT_W-1:0]  CNT_RST   = 3'h0;
	localparam logic [CNT_W-1:0]  CNT_LAST  = 3'h7;
endpackage

/* File: design/espc_sync.sv */
module espc_sync #(
	parameter int unsigned       W   = 1,
	parameter logic [W-1:0]      RST = '0
) (
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] stage1;
	logic [W-1:0] next_stage1;
	logic [W-1:0] next_sync;

	if (W < 1) begin : g_bad_width
		$error("espc_sync: width must be at least 1");
	end

	always_comb begin
		next_stage1 = async_i;
		next_sync   = stage1;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			stage1 <= RST;
			sync_o <= RST;
		end else begin
			stage1 <= next_stage1;
			sync_o <= next_sync;
		end
	end
endmodule // espc_sync

/* File: design/espc_pin_ctrl.sv */
// What this block does
// [R1] select high means deselected, output floating; select low means active
// [R2] standby only when deselected and no self-timed write is running
// [R3] nothing is accepted until a select falling edge after power-on
// [R4] data input bits are captured on serial clock rising edges
// [R5] data output changes after each serial clock falling edge
// [R6] master sends instructions, addresses and data on the data input only
// [R7] protect low rejects writes; reads and everything else keep working
// [R8] protect falling before final data bit clears latch, no programming
// [R9] a started write cycle is not touched by protect or latch changes
// [R10] pause only recognised while selected
// [R11] pause begins on pause pin falling while clock low
// [R12] pause ends on pause pin rising while clock low
// [R13] while paused output floats, data and clock inputs ignored
// [R14] pause keeps bit and byte position for resumption
// [R15] deselect while paused resets sequence, pause survives reselection
// [R16] master uses clock modes zero-zero or one-one only
// [R17] clock may idle low or high between transfers
// [R18] all fields shift most significant bit first
// [R19] write enable latch needed for writes, cleared by protect low
// [R20] bit counter restarts whenever select rises
module espc_pin_ctrl (
	input  wire logic                        clk_i,
	input  wire logic                        resetn_i,
	input  wire logic                        cs_n_i,
	input  wire logic                        sck_i,
	input  wire logic                        mosi_i,
	input  wire logic                        wp_n_i,
	input  wire logic                        hold_n_i,
	input  wire logic [espc_pkg::BYTE_W-1:0] tx_byte_i,
	input  wire logic                        wel_set_i,
	input  wire logic                        wel_clear_i,
	input  wire logic                        write_stream_i,
	input  wire logic                        prog_req_i,
	input  wire logic                        write_busy_i,
	output logic                             miso_o,
	output logic                             miso_oe_o,
	output logic [espc_pkg::BYTE_W-1:0]      rx_byte_o,
	output logic                             rx_valid_o,
	output logic                             wel_o,
	output logic                             program_start_o,
	output logic                             active_o,
	output logic                             standby_o,
	output logic                             paused_o
);
	logic [espc_pkg::PIN_N-1:0]  pins_s;
	logic                        cs_n_s;
	logic                        sck_s;
	logic                        mosi_s;
	logic                        wp_n_s;
	logic                        hold_n_s;

	logic                        prev_cs;
	logic                        prev_sck;
	logic                        prev_hold;
	logic                        prev_wp;
	logic                        armed;
	logic                        abort;
	logic [espc_pkg::CNT_W-1:0]  bit_cnt;
	logic [espc_pkg::BYTE_W-1:0] rx_shift;
	logic [espc_pkg::BYTE_W-1:0] tx_shift;

	logic                        next_armed;
	logic                        next_paused;
	logic                        next_abort;
	logic [espc_pkg::CNT_W-1:0]  next_bit_cnt;
	logic [espc_pkg::BYTE_W-1:0] next_rx_shift;
	logic [espc_pkg::BYTE_W-1:0] next_tx_shift;
	logic [espc_pkg::BYTE_W-1:0] next_rx_byte;
	logic                        next_rx_valid;
	logic                        next_miso;
	logic                        next_miso_oe;
	logic                        next_wel;
	logic                        next_prog;
	logic                        next_active;
	logic                        next_standby;

	logic cs_fall;
	logic cs_rise;
	logic sck_rise;
	logic sck_fall;
	logic hold_fall;
	logic hold_rise;
	logic wp_fall;
	logic live;

	////////////////////////////////////////////////////////////////////////
	espc_sync #(
		.W   (espc_pkg::PIN_N),
		.RST (espc_pkg::PIN_RST)
	) espc_sync_inst (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.async_i  ({hold_n_i, wp_n_i, mosi_i, sck_i, cs_n_i}),
		.sync_o   (pins_s)
	);

	assign cs_n_s   = pins_s[espc_pkg::PIN_CS];
	assign sck_s    = pins_s[espc_pkg::PIN_SCK];
	assign mosi_s   = pins_s[espc_pkg::PIN_MOSI];
	assign wp_n_s   = pins_s[espc_pkg::PIN_WP];
	assign hold_n_s = pins_s[espc_pkg::PIN_HOLD];

	assign cs_fall   = prev_cs & ~cs_n_s;
	assign cs_rise   = ~prev_cs & cs_n_s;
	assign sck_rise  = ~prev_sck & sck_s;
	assign sck_fall  = prev_sck & ~sck_s;
	assign hold_fall = prev_hold & ~hold_n_s;
	assign hold_rise = ~prev_hold & hold_n_s;
	assign wp_fall   = prev_wp & ~wp_n_s;
	// transfer may advance: armed, selected, not paused
	assign live      = armed & ~cs_n_s & ~paused_o;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_armed    = armed | cs_fall; // see [R3]
		next_paused   = paused_o;
		next_bit_cnt  = bit_cnt;
		next_rx_shift = rx_shift;
		next_tx_shift = tx_shift;
		next_rx_byte  = rx_byte_o;
		next_rx_valid = 1'b0;
		next_miso     = miso_o;
		// pause pin seen only while selected, clock low
		if (!cs_n_s && !sck_s && hold_fall) begin // see [R10] see [R11]
			next_paused = 1'b1;
		end else if (!cs_n_s && !sck_s && hold_rise) begin // see [R12]
			next_paused = 1'b0;
		end
		if (cs_rise) begin
			// sequence restarts, pause flag is kept
			next_bit_cnt  = espc_pkg::CNT_RST; // see [R20] see [R15]
			next_rx_shift = espc_pkg::SHIFT_RST;
			next_tx_shift = espc_pkg::SHIFT_RST;
		end else if (live && sck_rise) begin // see [R4] see [R13] see [R17]
			next_rx_shift = {rx_shift[espc_pkg::BYTE_W-2:0], mosi_s}; // see [R18]
			next_bit_cnt  = bit_cnt + 3'h1;
			if (bit_cnt == espc_pkg::CNT_LAST) begin
				next_rx_byte  = {rx_shift[espc_pkg::BYTE_W-2:0], mosi_s};
				next_rx_valid = 1'b1;
			end
		end else if (live && sck_fall) begin // see [R5] see [R14]
			if (bit_cnt == espc_pkg::CNT_RST) begin
				next_miso     = tx_byte_i[espc_pkg::BYTE_W-1]; // see [R18]
				next_tx_shift = {tx_byte_i[espc_pkg::BYTE_W-2:0], 1'b0};
			end else begin
				next_miso     = tx_shift[espc_pkg::BYTE_W-1];
				next_tx_shift = {tx_shift[espc_pkg::BYTE_W-2:0], 1'b0};
			end
		end
		next_miso_oe = armed & ~cs_n_s & ~paused_o; // see [R1] see [R13]
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			prev_cs    <= 1'b1;
			prev_sck   <= 1'b0;
			prev_hold  <= 1'b1;
			prev_wp    <= 1'b1;
			armed      <= 1'b0;
			paused_o   <= 1'b0;
			bit_cnt    <= espc_pkg::CNT_RST;
			rx_shift   <= espc_pkg::SHIFT_RST;
			tx_shift   <= espc_pkg::SHIFT_RST;
			rx_byte_o  <= espc_pkg::SHIFT_RST;
			rx_valid_o <= 1'b0;
			miso_o     <= 1'b0;
			miso_oe_o  <= 1'b0;
		end else begin
			prev_cs    <= cs_n_s;
			prev_sck   <= sck_s;
			prev_hold  <= hold_n_s;
			prev_wp    <= wp_n_s;
			armed      <= next_armed;
			paused_o   <= next_paused;
			bit_cnt    <= next_bit_cnt;
			rx_shift   <= next_rx_shift;
			tx_shift   <= next_tx_shift;
			rx_byte_o  <= next_rx_byte;
			rx_valid_o <= next_rx_valid;
			miso_o     <= next_miso;
			miso_oe_o  <= next_miso_oe;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		// a set while protect is high wins over a command clear
		if (wel_set_i && wp_n_s) begin // see [R7]
			next_wel = 1'b1;
		end else if (wel_clear_i || !wp_n_s) begin // see [R19]
			next_wel = 1'b0;
		end else begin
			next_wel = wel_o;
		end
		next_abort = abort;
		if (wp_fall && write_stream_i) begin // see [R8]
			next_abort = 1'b1;
		end else if (cs_fall) begin
			next_abort = 1'b0;
		end
		// busy write is left alone; only a fresh start is gated
		next_prog = prog_req_i & wel_o & wp_n_s & ~abort // see [R8] see [R7]
			& ~write_busy_i; // see [R9]
		next_active = ~cs_n_s | write_busy_i; // see [R1] see [R2]
		next_standby = ~next_active;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wel_o           <= 1'b0;
			abort           <= 1'b0;
			program_start_o <= 1'b0;
			active_o        <= 1'b0;
			standby_o       <= 1'b1;
		end else begin
			wel_o           <= next_wel;
			abort           <= next_abort;
			program_start_o <= next_prog;
			active_o        <= next_active;
			standby_o       <= next_standby;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	deselect_hiz_a: assert property (cs_n_s |=> !miso_oe_o) // see [R1]
		else $error("output enabled while deselected");
	pause_hiz_a: assert property (paused_o |=> !miso_oe_o) // see [R13]
		else $error("output enabled during pause");
	unarmed_quiet_a: assert property (!armed |=> !rx_valid_o) // see [R3]
		else $error("byte taken before first select edge");
	standby_mode_a: assert property // see [R2]
		(cs_n_s && !write_busy_i |=> standby_o && !active_o)
		else $error("standby not entered when idle");
	busy_active_a: assert property (write_busy_i |=> active_o) // see [R2]
		else $error("standby during self-timed write");
	wp_clears_wel_a: assert property (!wp_n_s |=> !wel_o) // see [R19]
		else $error("latch kept while protect low");
	wp_blocks_prog_a: assert property // see [R7]
		(program_start_o |-> $past(wp_n_s) && $past(wel_o))
		else $error("programming started while protected");
	abort_prog_a: assert property // see [R8]
		(wp_fall && write_stream_i ##1 !cs_fall [*2] |=> !program_start_o)
		else $error("programming after protect fell in stream");
	cs_rise_cnt_a: assert property (cs_rise |=> bit_cnt == 3'h0) // see [R20]
		else $error("bit counter not restarted on deselect");
	pause_keeps_a: assert property // see [R14]
		(paused_o && !cs_rise |=> $stable(bit_cnt) && $stable(rx_shift))
		else $error("transfer advanced during pause");
	pause_survive_a: assert property // see [R15]
		(paused_o && cs_n_s |=> paused_o)
		else $error("pause lost across deselect");
	rx_edge_a: assert property (rx_valid_o |-> $past(sck_rise)) // see [R4]
		else $error("byte completed off a rising edge");
	miso_edge_a: assert property (!$stable(miso_o) |-> $past(sck_fall)) // see [R5]
		else $error("output changed off a falling edge");
endmodule // espc_pin_ctrl

/* File: bench/espc_master_model.sv */
module espc_master_model (
	input  wire logic miso_i,
	input  wire logic miso_oe_i,
	output logic      cs_n_o,
	output logic      sck_o,
	output logic      mosi_o,
	output logic      hold_n_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic      last = 1'b0;
	wire logic line = miso_oe_i ? miso_i : ~last;
	// released output line shows the inverse of its last driven value
	always @(miso_i or miso_oe_i) if (miso_oe_i) last = miso_i;
	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		mosi_o = 1'b0;
		hold_n_o = 1'b1;
	end
	// bits hi..lo, driven after the fall, sampled on the rise
	task automatic shift(input logic [7:0] d, input int hi, input int lo,
			output logic [7:0] q);
		q = 8'h00;
		for (int i = hi; i >= lo; i--) begin
			sck_o  <= 1'b0;
			mosi_o <= d[i];
			#24;
			sck_o <= 1'b1;
			q[i] = line;
			#24;
		end
	endtask
endmodule // espc_master_model

/* File: bench/test_espc_pin_ctrl.sv */
module test_espc_pin_ctrl;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk_i, resetn_i, wp_n_i, wel_set_i, wel_clear_i;
	logic       write_stream_i, prog_req_i, write_busy_i;
	logic [7:0] tx_byte_i, rx_byte_o, nval;
	logic       miso_o, miso_oe_o, rx_valid_o, wel_o, program_start_o;
	logic       active_o, standby_o, paused_o;
	wire logic  cs_n_i, sck_i, mosi_i, hold_n_i;
	int         fails, num_checks, cyc;
	espc_pin_ctrl espc_pin_ctrl_inst (.clk_i, .resetn_i, .cs_n_i, .sck_i,
		.mosi_i, .wp_n_i, .hold_n_i, .tx_byte_i, .wel_set_i, .wel_clear_i,
		.write_stream_i, .prog_req_i, .write_busy_i, .miso_o, .miso_oe_o,
		.rx_byte_o, .rx_valid_o, .wel_o, .program_start_o, .active_o,
		.standby_o, .paused_o);
	espc_master_model m (.miso_i(miso_o), .miso_oe_i(miso_oe_o),
		.cs_n_o(cs_n_i), .sck_o(sck_i), .mosi_o(mosi_i), .hold_n_o(hold_n_i));
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (rx_valid_o === 1'b1) nval <= nval + 8'h01;
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			fails++;
			final_report;
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one-cycle command pulse {set, clear, program}
	task automatic ctl(input logic [2:0] v);
		@(posedge clk_i);
		{wel_set_i, wel_clear_i, prog_req_i} <= v;
		@(posedge clk_i);
		{wel_set_i, wel_clear_i, prog_req_i} <= 3'h0;
		#1;
	endtask
	task automatic final_report;
		if (fails == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_idle;
		logic [7:0] q;
		m.shift(8'hff, 7, 0, q);
		m.sck_o    <= 1'b0;
		m.hold_n_o <= 1'b0;
		#50 @(negedge clk_i) chk(paused_o, 1'b0);
		m.hold_n_o <= 1'b1;
		chk(nval, 8'h00);
		chk(miso_oe_o, 1'b0);
	endtask
	task automatic t_mode(input logic md);
		logic [7:0] q;
		@(posedge clk_i);
		tx_byte_i <= 8'h3c;
		m.sck_o   <= md;
		#50 m.cs_n_o <= 1'b0;
		#50 @(negedge clk_i) chk(active_o, 1'b1);
		chk(miso_oe_o, 1'b1);
		m.shift(8'h96, 7, 0, q);
		#50 @(negedge clk_i) chk(rx_byte_o, 8'h96);
		m.shift(8'h4b, 7, 0, q);
		#50 @(negedge clk_i) chk(rx_byte_o, 8'h4b);
		chk(q, 8'h3c);
		m.sck_o <= md;
		#50 m.cs_n_o <= 1'b1;
		#50 @(negedge clk_i) chk(miso_oe_o, 1'b0);
		chk(standby_o, 1'b1);
	endtask
	task automatic t_pause;
		logic [7:0] q;
		m.cs_n_o <= 1'b0;
		m.shift(8'ha5, 7, 4, q);
		m.sck_o <= 1'b0;
		#24 m.hold_n_o <= 1'b0;
		#50 @(negedge clk_i) chk(paused_o, 1'b1);
		chk(miso_oe_o, 1'b0);
		m.shift(8'hff, 7, 4, q);
		m.sck_o <= 1'b0;
		#24 m.hold_n_o <= 1'b1;
		#50 @(negedge clk_i) chk(paused_o, 1'b0);
		m.shift(8'ha5, 3, 0, q);
		#50 @(negedge clk_i) chk(rx_byte_o, 8'ha5);
		m.shift(8'hc3, 7, 5, q);
		m.sck_o <= 1'b0;
		#24 m.hold_n_o <= 1'b0;
		#50 m.cs_n_o <= 1'b1;
		#50 m.cs_n_o <= 1'b0;
		#50 @(negedge clk_i) chk(paused_o, 1'b1);
		m.hold_n_o <= 1'b1;
		#50 m.shift(8'h5a, 7, 0, q);
		#50 @(negedge clk_i) chk(rx_byte_o, 8'h5a);
		m.sck_o <= 1'b0;
		#50 m.cs_n_o <= 1'b1;
	endtask
	task automatic t_wp;
		ctl(3'h4);
		chk(wel_o, 1'b1);
		ctl(3'h1);
		chk(program_start_o, 1'b1);
		@(posedge clk_i);
		write_stream_i <= 1'b1;
		wp_n_i         <= 1'b0;
		#50 @(negedge clk_i) chk(wel_o, 1'b0);
		ctl(3'h1);
		chk(program_start_o, 1'b0);
		ctl(3'h4);
		chk(wel_o, 1'b0);
		// protect back high, but abort stays until the next select
		@(posedge clk_i);
		wp_n_i <= 1'b1;
		#50 ctl(3'h4);
		chk(wel_o, 1'b1);
		ctl(3'h1);
		chk(program_start_o, 1'b0);
		@(posedge clk_i);
		wp_n_i <= 1'b0;
		t_mode(1'b0);
		@(posedge clk_i);
		wp_n_i         <= 1'b1;
		write_stream_i <= 1'b0;
		m.cs_n_o       <= 1'b0;
		#50 m.cs_n_o <= 1'b1;
		#50 ctl(3'h4);
		ctl(3'h1);
		chk(program_start_o, 1'b1);
		@(posedge clk_i);
		write_busy_i <= 1'b1;
		#50 @(negedge clk_i) chk(active_o, 1'b1);
		ctl(3'h1);
		chk(program_start_o, 1'b0);
		@(posedge clk_i);
		write_busy_i <= 1'b0;
		#50 @(negedge clk_i) chk(standby_o, 1'b1);
		ctl(3'h2);
		chk(wel_o, 1'b0);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{resetn_i, wel_set_i, wel_clear_i, prog_req_i} = 4'h0;
		{write_stream_i, write_busy_i, wp_n_i} = 3'h1;
		{tx_byte_i, nval, fails, num_checks, cyc} = '0;
		repeat (6) @(posedge clk_i);
		resetn_i <= 1'b1;
		#50 @(negedge clk_i) chk(standby_o, 1'b1);
		chk(active_o, 1'b0);
		chk(wel_o, 1'b0);
		t_idle;
		t_mode(1'b0);
		t_mode(1'b1);
		t_pause;
		t_wp;
		chk(nval, 8'h08);
		final_report;
	end
endmodule // test_espc_pin_ctrl
